// ### src/t1_tx_maint_consts.svh
`ifndef T1_TX_MAINT_CONSTS_SVH
`define T1_TX_MAINT_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define IDX_MODE 8'h62
`define IDX_MAINT 8'h6C
`define IDX_IRQ_EN 8'h6D
`define IDX_FRM_FLAGS 8'h6E
`define IDX_ERR_INJ 8'h6F
`define IDX_TIMING 8'h70
`define IDX_PRBS_CTRL 8'h71
`define IDX_PRBS_STAT 8'h72
`define IDX_PRBS_FLAGS 8'h73
`define IDX_LB_CTRL 8'h74
`define IDX_LB_CODE 8'h75

// Field positions.
`define MODE_FRAMING_GENERATION_OFF 0
`define MODE_FMT_LO 3
`define MODE_FMT_HI 4
`define MODE_CLK_LO 5
`define MODE_CLK_HI 6
`define MODE_PRBS_TX 7
`define MAINT_MIMIC 3
`define MAINT_SHIFT 2
`define MAINT_ZERO 1
`define MAINT_ONES 0
`define IRQEN_MF 5
`define IRQEN_BF 4
`define FLAG_MF 1
`define FLAG_BF 0
`define ERR_DDS 3
`define ERR_CRC 2
`define ERR_FS 1
`define ERR_FT 0
`define TIMING_SRC 0
`define PRBS_RXFLIP 3
`define PRBS_TXFLIP 2
`define PRBS_SEL_HI 1
`define PRBS_SEL_LO 0
`define PSTAT_ERR_EN 3
`define PSTAT_INJECT 2
`define PSTAT_LOCK 1
`define PSTAT_LOCK_EN 0
`define PFLAG_ERR 3
`define PFLAG_LOCK 0
`define LB_EN 3
`define LB_UNFRAMED 2
`define LB_LEN_HI 1
`define LB_LEN_LO 0

// Reset values.
`define RST_BYTE 8'h00
`define RST_NIBBLE 4'h0
`define RST_PAIR 2'h0
`define PRBS_SEED 20'h00001

// Frame and loop code geometry.
`define FRAME_LAST_BIT 8'hC0
`define MIMIC_BIT 8'h01
`define SF_LAST_FRAME 7'h0B
`define ESF_LAST_FRAME 7'h17
`define SLC_LAST_FRAME 7'h47
`define DDS_FIRST_BIT 8'hB9
`define DDS_LAST_BIT 8'hBE
`define ESF_CRC_SLOT 2'h1
`define ESF_FAS_SLOT 2'h3
`define LB_BASE_LAST 3'h4
`define LB_MSB 3'h7

// Transmit clock source codes.
`define CLKSRC_INTERNAL 2'h0
`define CLKSRC_RECOVERED 2'h1
`define CLKSRC_BACKPLANE 2'h2

// Pattern detector and bus response.
`define PRBS_WINDOW 48
`define PRBS_ERR_LIMIT 10
`define PRBS_SYNC_RUN 48
`define HRESP_OKAY 1'h0
`endif

// ### src/t1_tx_maint_pkg.sv
package t1_tx_maint_pkg;
	typedef enum logic [1:0] {FMT_SF, FMT_ESF, FMT_DM, FMT_SLC96} frame_format_e;
	typedef enum logic [1:0] {CLK_MASTER, CLK_SLAVE, CLK_SLAVE_E1, CLK_MUX} clock_mode_e;
	typedef enum logic {DET_HUNT, DET_LOCKED} detect_state_e;
endpackage

// ### src/prbs_if.sv
`timescale 1ns/1ps
interface prbs_if;
	logic [1:0] patternSel;
	logic txFlip;
	logic rxFlip;
	logic injectReq;
	logic injectDone;
	logic genAdvance;
	logic genBit;
	logic rxAdvance;
	logic rxBit;
	logic lockStatus;
	logic bitError;
	modport ctrl (output patternSel, output txFlip, output rxFlip, output injectReq,
		output genAdvance, output rxAdvance, output rxBit,
		input injectDone, input genBit, input lockStatus, input bitError);
	modport engine (input patternSel, input txFlip, input rxFlip, input injectReq,
		input genAdvance, input rxAdvance, input rxBit,
		output injectDone, output genBit, output lockStatus, output bitError);
endinterface

// ### src/prbs_gen_detect.sv
`timescale 1ns/1ps
`include "t1_tx_maint_consts.svh"
module prbs_gen_detect #(
	parameter int WINDOW = `PRBS_WINDOW,
	parameter int ERR_LIMIT = `PRBS_ERR_LIMIT,
	parameter int SYNC_RUN = `PRBS_SYNC_RUN
)(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Control side.
	prbs_if.engine port
);
	logic [19:0] genReg;
	logic [19:0] detReg;
	logic genFb;
	logic detExp;
	logic detIn;
	logic detErr;
	logic [5:0] runCnt_reg;
	logic [5:0] winCnt_reg;
	logic [3:0] errCnt_reg;
	t1_tx_maint_pkg::detect_state_e state_reg;

	function automatic logic feedback(input logic [19:0] sr, input logic [1:0] sel);
		case (sel)
			2'h1: feedback = sr[19] ^ sr[16];
			2'h2: feedback = sr[10] ^ sr[8];
			default: feedback = sr[14] ^ sr[13];
		endcase
	endfunction

	assign genFb = feedback(genReg, port.patternSel);
	assign port.genBit = genFb ^ port.txFlip ^ port.injectReq;
	assign port.injectDone = port.genAdvance & port.injectReq;
	assign detIn = port.rxBit ^ port.rxFlip;
	assign detExp = feedback(detReg, port.patternSel);
	assign detErr = detIn ^ detExp;
	assign port.lockStatus = (state_reg == t1_tx_maint_pkg::DET_LOCKED);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			genReg <= `PRBS_SEED;
		end else if (port.genAdvance) begin
			genReg <= (genReg == 20'h00000) ? `PRBS_SEED : {genReg[18:0], genFb};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			detReg <= `PRBS_SEED;
		end else if (port.rxAdvance) begin
			detReg <= {detReg[18:0], detIn};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= t1_tx_maint_pkg::DET_HUNT;
			runCnt_reg <= 6'h00;
			winCnt_reg <= 6'h00;
			errCnt_reg <= 4'h0;
		end else if (port.rxAdvance) begin
			case (state_reg)
				t1_tx_maint_pkg::DET_HUNT: begin
					runCnt_reg <= detErr ? 6'h00 : runCnt_reg + 6'h01;
					winCnt_reg <= 6'h00;
					errCnt_reg <= 4'h0;
					if (!detErr && runCnt_reg == 6'(SYNC_RUN - 1)) begin
						state_reg <= t1_tx_maint_pkg::DET_LOCKED;
					end
				end
				t1_tx_maint_pkg::DET_LOCKED: begin
					runCnt_reg <= 6'h00;
					if (detErr && errCnt_reg == 4'(ERR_LIMIT - 1)) begin
						state_reg <= t1_tx_maint_pkg::DET_HUNT;
					end
					if (winCnt_reg == 6'(WINDOW - 1)) begin
						winCnt_reg <= 6'h00;
						errCnt_reg <= 4'h0;
					end else begin
						winCnt_reg <= winCnt_reg + 6'h01;
						errCnt_reg <= errCnt_reg + {3'h0, detErr};
					end
				end
				default: state_reg <= t1_tx_maint_pkg::DET_HUNT;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			port.bitError <= 1'b0;
		end else begin
			port.bitError <= port.rxAdvance & detErr & port.lockStatus;
		end
	end
endmodule // prbs_gen_detect

// ### src/t1_tx_maintenance_prbs.sv
`timescale 1ns/1ps
`include "t1_tx_maint_consts.svh"
module t1_tx_maintenance_prbs (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Transmit stream.
	input wire logic txBitStrobe,
	input wire logic txDataIn,
	output logic txDataOut,
	output logic txDataValid,
	// Receive stream into the pattern detector.
	input wire logic rxBitStrobe,
	input wire logic rxDataIn,
	// Clock routing and interrupt.
	output logic [1:0] txClockSource,
	output logic txBufferBypass,
	output logic irq
);
	// Bus state.
	logic addrPhase;
	logic addrOk;
	logic wrPend_reg;
	logic rdWait_reg;
	logic [7:0] wrIdx_reg;
	logic [7:0] rdIdx_reg;
	logic [7:0] readByte;
	// Software registers.
	logic [7:0] modeReg;
	logic [3:0] maintReg;
	logic [1:0] irqEnReg;
	logic [1:0] frameFlagReg;
	logic [3:0] errReqReg;
	logic clkSrcSelReg;
	logic [3:0] prbsCtrlReg;
	logic prbsErrEnReg;
	logic injectReg;
	logic lockEnReg;
	logic prbsErrFlagReg;
	logic lockFlagReg;
	logic [3:0] lbCtrlReg;
	logic [7:0] lbCodeReg;
	// Stream state.
	logic [7:0] bitCnt_reg;
	logic [6:0] frameCnt_reg;
	logic [6:0] lastFrame;
	logic shiftPrev_reg;
	logic slipPend_reg;
	logic lastF_reg;
	logic crcActive_reg;
	logic ddsActive_reg;
	logic [2:0] lbPos_reg;
	logic lockPrev_reg;
	logic [3:0] errDone;
	logic framingOn;
	logic fBit;
	logic frameEnd;
	logic mfEnd;
	logic fsPos;
	logic ftPos;
	logic crcPos;
	logic ddsPos;
	logic lbUse;
	logic frameBit;
	logic outBit;
	t1_tx_maint_pkg::frame_format_e fmt;
	t1_tx_maint_pkg::clock_mode_e clkMode;
	prbs_if prbsBus();

	prbs_gen_detect engine (
		.clk(clk),
		.rst_n(rst_n),
		.port(prbsBus.engine)
	);

	assign fmt = t1_tx_maint_pkg::frame_format_e'(modeReg[`MODE_FMT_HI:`MODE_FMT_LO]);
	assign clkMode = t1_tx_maint_pkg::clock_mode_e'(modeReg[`MODE_CLK_HI:`MODE_CLK_LO]);
	assign framingOn = ~modeReg[`MODE_FRAMING_GENERATION_OFF];

	// Bus slave: writes take no wait state, reads one.
	assign addrPhase = hsel & htrans[1] & hready;
	assign addrOk = (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'h0);
	assign hreadyout = ~rdWait_reg;
	assign hresp = `HRESP_OKAY;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPend_reg <= 1'b0;
			rdWait_reg <= 1'b0;
			wrIdx_reg <= `RST_BYTE;
			rdIdx_reg <= `RST_BYTE;
		end else begin
			wrPend_reg <= addrPhase & hwrite & addrOk;
			rdWait_reg <= addrPhase & ~hwrite;
			wrIdx_reg <= haddr[9:2];
			rdIdx_reg <= addrOk ? haddr[9:2] : `RST_BYTE;
		end
	end

	always_comb begin
		readByte = `RST_BYTE;
		case (rdIdx_reg)
			`IDX_MODE: readByte = modeReg;
			`IDX_MAINT: readByte = {4'h0, maintReg};
			`IDX_IRQ_EN: readByte = {2'h0, irqEnReg, 4'h0};
			`IDX_FRM_FLAGS: readByte = {6'h00, frameFlagReg};
			`IDX_ERR_INJ: readByte = {4'h0, errReqReg};
			`IDX_TIMING: readByte = {7'h00, clkSrcSelReg};
			`IDX_PRBS_CTRL: readByte = {4'h0, prbsCtrlReg};
			`IDX_PRBS_STAT: readByte = {4'h0, prbsErrEnReg, injectReg, prbsBus.lockStatus,
				lockEnReg};
			`IDX_PRBS_FLAGS: readByte = {4'h0, prbsErrFlagReg, 2'h0, lockFlagReg};
			`IDX_LB_CTRL: readByte = {4'h0, lbCtrlReg};
			`IDX_LB_CODE: readByte = lbCodeReg;
			default: readByte = `RST_BYTE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hrdata <= 32'h00000000;
		end else if (rdWait_reg) begin
			hrdata <= {24'h000000, readByte};
		end
	end

	// Plain read/write control registers.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			modeReg <= `RST_BYTE;
			maintReg <= `RST_NIBBLE;
			irqEnReg <= `RST_PAIR;
			clkSrcSelReg <= 1'b0;
			prbsCtrlReg <= `RST_NIBBLE;
			prbsErrEnReg <= 1'b0;
			lockEnReg <= 1'b0;
			lbCtrlReg <= `RST_NIBBLE;
			lbCodeReg <= `RST_BYTE;
		end else if (wrPend_reg) begin
			case (wrIdx_reg)
				`IDX_MODE: modeReg <= hwdata[7:0];
				`IDX_MAINT: maintReg <= hwdata[`MAINT_MIMIC:`MAINT_ONES];
				`IDX_IRQ_EN: irqEnReg <= hwdata[`IRQEN_MF:`IRQEN_BF];
				`IDX_TIMING: clkSrcSelReg <= hwdata[`TIMING_SRC];
				`IDX_PRBS_CTRL: prbsCtrlReg <= hwdata[`PRBS_RXFLIP:`PRBS_SEL_LO];
				`IDX_PRBS_STAT: begin
					prbsErrEnReg <= hwdata[`PSTAT_ERR_EN];
					lockEnReg <= hwdata[`PSTAT_LOCK_EN];
				end
				`IDX_LB_CTRL: lbCtrlReg <= hwdata[`LB_EN:`LB_LEN_LO];
				`IDX_LB_CODE: lbCodeReg <= hwdata[7:0];
				default: lbCodeReg <= lbCodeReg;
			endcase
		end
	end

	// Frame position decode.
	always_comb begin
		case (fmt)
			t1_tx_maint_pkg::FMT_ESF: lastFrame = `ESF_LAST_FRAME;
			t1_tx_maint_pkg::FMT_SLC96: lastFrame = `SLC_LAST_FRAME;
			default: lastFrame = `SF_LAST_FRAME;
		endcase
	end

	assign fBit = (bitCnt_reg == 8'h00);
	assign frameEnd = (bitCnt_reg == `FRAME_LAST_BIT);
	assign mfEnd = frameEnd & (frameCnt_reg == lastFrame);
	assign crcPos = fBit & (fmt == t1_tx_maint_pkg::FMT_ESF) & (frameCnt_reg[1:0] == `ESF_CRC_SLOT);
	assign fsPos = fBit & ((fmt == t1_tx_maint_pkg::FMT_ESF) ?
		(frameCnt_reg[1:0] == `ESF_FAS_SLOT) : frameCnt_reg[0]);
	assign ftPos = fBit & (fmt != t1_tx_maint_pkg::FMT_ESF) & ~frameCnt_reg[0];
	assign ddsPos = (fmt == t1_tx_maint_pkg::FMT_DM) & (bitCnt_reg >= `DDS_FIRST_BIT) &
		(bitCnt_reg <= `DDS_LAST_BIT);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shiftPrev_reg <= 1'b0;
			slipPend_reg <= 1'b0;
		end else begin
			shiftPrev_reg <= maintReg[`MAINT_SHIFT];
			if (shiftPrev_reg != maintReg[`MAINT_SHIFT]) begin
				slipPend_reg <= 1'b1;
			end else if (txBitStrobe) begin
				slipPend_reg <= 1'b0;
			end
		end
	end

	// A pending slip holds the position for one bit, so one bit position repeats.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bitCnt_reg <= 8'h00;
			frameCnt_reg <= 7'h00;
		end else if (txBitStrobe && !slipPend_reg) begin
			bitCnt_reg <= frameEnd ? 8'h00 : bitCnt_reg + 8'h01;
			if (mfEnd || (frameEnd && frameCnt_reg > lastFrame)) begin
				frameCnt_reg <= 7'h00;
			end else if (frameEnd) begin
				frameCnt_reg <= frameCnt_reg + 7'h01;
			end
		end
	end

	// whole CRC word; whole DDS pattern
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			crcActive_reg <= 1'b0;
			ddsActive_reg <= 1'b0;
		end else if (txBitStrobe) begin
			if (fBit && frameCnt_reg == 7'h00 && errReqReg[`ERR_CRC] && framingOn &&
				fmt == t1_tx_maint_pkg::FMT_ESF) begin
				crcActive_reg <= 1'b1;
			end else if (mfEnd) begin
				crcActive_reg <= 1'b0;
			end
			if (fBit && errReqReg[`ERR_DDS] && framingOn && fmt == t1_tx_maint_pkg::FMT_DM) begin
				ddsActive_reg <= 1'b1;
			end else if (frameEnd) begin
				ddsActive_reg <= 1'b0;
			end
		end
	end

	assign errDone[`ERR_CRC] = txBitStrobe & crcActive_reg & mfEnd;
	assign errDone[`ERR_DDS] = txBitStrobe & ddsActive_reg & frameEnd;
	assign errDone[`ERR_FS] = txBitStrobe & errReqReg[`ERR_FS] & framingOn & fsPos;
	assign errDone[`ERR_FT] = txBitStrobe & errReqReg[`ERR_FT] & framingOn & ftPos;

	// Request bits are set by software and cleared by hardware once the inversion is done.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			errReqReg <= `RST_NIBBLE;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (errDone[i]) begin
					errReqReg[i] <= 1'b0;
				end else if (wrPend_reg && wrIdx_reg == `IDX_ERR_INJ) begin
					errReqReg[i] <= hwdata[i];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			injectReg <= 1'b0;
		end else if (prbsBus.injectDone) begin
			injectReg <= 1'b0;
		end else if (wrPend_reg && wrIdx_reg == `IDX_PRBS_STAT) begin
			injectReg <= hwdata[`PSTAT_INJECT];
		end
	end

	assign prbsBus.patternSel = prbsCtrlReg[`PRBS_SEL_HI:`PRBS_SEL_LO];
	assign prbsBus.txFlip = prbsCtrlReg[`PRBS_TXFLIP];
	assign prbsBus.rxFlip = prbsCtrlReg[`PRBS_RXFLIP];
	assign prbsBus.injectReq = injectReg;
	assign prbsBus.genAdvance = txBitStrobe & modeReg[`MODE_PRBS_TX] & ~fBit;
	assign prbsBus.rxAdvance = rxBitStrobe;
	assign prbsBus.rxBit = rxDataIn;

	// code only while enabled; framed or unframed
	assign lbUse = lbCtrlReg[`LB_EN] & (lbCtrlReg[`LB_UNFRAMED] | ~fBit);

	// Outgoing bit, built in order of increasing precedence.
	always_comb begin
		frameBit = txDataIn;
		if (modeReg[`MODE_PRBS_TX] && !fBit) begin
			frameBit = prbsBus.genBit;
		end
		if (framingOn && maintReg[`MAINT_MIMIC] && bitCnt_reg == `MIMIC_BIT) begin
			frameBit = lastF_reg;
		end
		if ((crcActive_reg && crcPos) || (ddsActive_reg && ddsPos) ||
			errDone[`ERR_FS] || errDone[`ERR_FT]) begin
			frameBit = ~frameBit;
		end
		outBit = frameBit;
		if (lbUse) begin
			outBit = lbCodeReg[`LB_MSB - lbPos_reg];
		end
		if (maintReg[`MAINT_ONES]) begin
			outBit = 1'b1;
		end
		if (maintReg[`MAINT_ZERO]) begin
			outBit = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lbPos_reg <= 3'h0;
		end else if (!lbCtrlReg[`LB_EN]) begin
			lbPos_reg <= 3'h0;
		end else if (txBitStrobe && lbUse) begin
			if (lbPos_reg >= `LB_BASE_LAST + {1'b0, lbCtrlReg[`LB_LEN_HI:`LB_LEN_LO]}) begin
				lbPos_reg <= 3'h0;
			end else begin
				lbPos_reg <= lbPos_reg + 3'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txDataOut <= 1'b0;
			txDataValid <= 1'b0;
			lastF_reg <= 1'b0;
		end else begin
			txDataValid <= txBitStrobe;
			if (txBitStrobe) begin
				txDataOut <= outBit;
			end
			if (txBitStrobe && fBit) begin
				lastF_reg <= frameBit;
			end
		end
	end

	// start flags, set wins over clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			frameFlagReg <= `RST_PAIR;
		end else begin
			if (txBitStrobe && fBit && frameCnt_reg == 7'h00) begin
				frameFlagReg[`FLAG_MF] <= 1'b1;
			end else if (wrPend_reg && wrIdx_reg == `IDX_FRM_FLAGS && hwdata[`FLAG_MF]) begin
				frameFlagReg[`FLAG_MF] <= 1'b0;
			end
			if (txBitStrobe && fBit) begin
				frameFlagReg[`FLAG_BF] <= 1'b1;
			end else if (wrPend_reg && wrIdx_reg == `IDX_FRM_FLAGS && hwdata[`FLAG_BF]) begin
				frameFlagReg[`FLAG_BF] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lockPrev_reg <= 1'b0;
			prbsErrFlagReg <= 1'b0;
			lockFlagReg <= 1'b0;
		end else begin
			lockPrev_reg <= prbsBus.lockStatus;
			if (prbsBus.bitError) begin
				prbsErrFlagReg <= 1'b1;
			end else if (wrPend_reg && wrIdx_reg == `IDX_PRBS_FLAGS && hwdata[`PFLAG_ERR]) begin
				prbsErrFlagReg <= 1'b0;
			end
			if (lockPrev_reg != prbsBus.lockStatus) begin
				lockFlagReg <= 1'b1;
			end else if (wrPend_reg && wrIdx_reg == `IDX_PRBS_FLAGS && hwdata[`PFLAG_LOCK]) begin
				lockFlagReg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= (frameFlagReg[`FLAG_MF] & irqEnReg[1]) | (frameFlagReg[`FLAG_BF] & irqEnReg[0]) |
				(prbsErrFlagReg & prbsErrEnReg) | (lockFlagReg & lockEnReg);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txClockSource <= `CLKSRC_INTERNAL;
			txBufferBypass <= 1'b1;
		end else begin
			case (clkMode)
				t1_tx_maint_pkg::CLK_MASTER: begin
					txClockSource <= clkSrcSelReg ? `CLKSRC_RECOVERED : `CLKSRC_INTERNAL;
					txBufferBypass <= 1'b1;
				end
				t1_tx_maint_pkg::CLK_SLAVE_E1: begin
					txClockSource <= `CLKSRC_BACKPLANE;
					txBufferBypass <= 1'b1;
				end
				default: begin
					txClockSource <= clkSrcSelReg ? `CLKSRC_INTERNAL : `CLKSRC_BACKPLANE;
					txBufferBypass <= ~clkSrcSelReg;
				end
			endcase
		end
	end
endmodule // t1_tx_maintenance_prbs

// ### test/t1_tx_maintenance_prbs_properties.sv
`timescale 1ns/1ps
module t1_tx_maintenance_prbs_properties (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Register bus.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// Transmit stream.
	input wire logic txBitStrobe,
	input wire logic txDataOut,
	input wire logic txDataValid
);
	logic wrPend;
	logic [31:0] wrAddr;
	logic zeroOn;
	logic onesOn;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPend <= 1'b0;
			wrAddr <= 32'h00000000;
		end else if (hready) begin
			wrPend <= hsel && htrans[1] && hwrite;
			wrAddr <= haddr;
		end
	end
	// Shadow copy of the two overwrite controls, taken from completed bus writes.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			zeroOn <= 1'b0;
			onesOn <= 1'b0;
		end else if (wrPend && hready && wrAddr == 32'h000001B0) begin
			zeroOn <= hwdata[1];
			onesOn <= hwdata[0];
		end
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("bus response not OKAY");
	a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read data phase not one wait state");
	a_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
		else $error("write data phase stalled");
	a_rdata_upper: assert property (hreadyout |-> hrdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	a_valid_follows: assert property (txBitStrobe |=> txDataValid)
		else $error("no output bit after strobe");
	a_valid_cause: assert property (txDataValid |-> $past(txBitStrobe))
		else $error("output bit without strobe");
	a_out_holds: assert property (!txDataValid |-> $stable(txDataOut))
		else $error("output bit changed between strobes");
	a_zero_wins: assert property (txDataValid && $past(zeroOn) |-> !txDataOut)
		else $error("zero overwrite not applied");
	a_ones_fill: assert property (txDataValid && $past(onesOn) && !$past(zeroOn) |-> txDataOut)
		else $error("ones overwrite not applied");
endmodule // t1_tx_maintenance_prbs_properties

bind t1_tx_maintenance_prbs t1_tx_maintenance_prbs_properties props (.clk(clk), .rst_n(rst_n),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.txBitStrobe(txBitStrobe), .txDataOut(txDataOut), .txDataValid(txDataValid));

// ### test/t1_line_model.sv
`timescale 1ns/1ps
module t1_line_model (
	// Clock, reset and enable.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	// Block side.
	input wire logic txDataOut,
	input wire logic txDataValid,
	output logic txBitStrobe,
	output logic txDataIn,
	output logic rxBitStrobe,
	output logic rxDataIn,
	output logic sentBit
);
	logic [7:0] pos;
	logic [7:0] sentPos;
	initial begin
		txBitStrobe = 1'b0;
		txDataIn = 1'b0;
		rxBitStrobe = 1'b0;
		rxDataIn = 1'b0;
	end
	// One bit every second cycle; the position count follows the block's bit count.
	always @(posedge clk) begin
		if (!rst_n) begin
			txBitStrobe <= 1'b0;
			pos <= 8'h00;
			sentPos <= 8'h00;
		end else begin
			txBitStrobe <= run && !txBitStrobe;
			if (txBitStrobe) begin
				pos <= (pos == 8'hC0) ? 8'h00 : pos + 8'h01;
				sentPos <= pos;
				sentBit <= txDataIn;
			end
		end
	end
	// Data is only meaningful under a strobe; elsewhere it keeps changing.
	always @(posedge clk) begin
		txDataIn <= txBitStrobe ? ~txDataIn : pos[0] ^ pos[2];
	end
	// Payload bits go back into the detector; framing positions are left out.
	always @(posedge clk) begin
		rxBitStrobe <= txDataValid && sentPos != 8'h00;
		rxDataIn <= txDataValid ? txDataOut : ~rxDataIn;
	end
endmodule // t1_line_model

// ### test/t1_tx_maintenance_prbs_tb.sv
`timescale 1ns/1ps
module t1_tx_maintenance_prbs_tb;
	typedef struct packed {logic [31:0] addr; logic [7:0] wdata; logic [7:0] rdata;} reg_row_s;
	logic clk, rst_n, hsel, hwrite, hreadyout, hresp, run, sentBit, irq, txBufferBypass;
	logic txBitStrobe, txDataIn, txDataOut, txDataValid, rxBitStrobe, rxDataIn;
	logic [31:0] haddr, hwdata, hrdata, v;
	logic [1:0] htrans, txClockSource;
	int n_errors, checks, i, m, s, t, es, ones;
	reg_row_s rows [8] = '{'{32'h1B0, 8'h0B, 8'h0B}, '{32'h1B4, 8'h30, 8'h30},
		'{32'h1C0, 8'h01, 8'h01}, '{32'h1C4, 8'h0F, 8'h0F}, '{32'h1C8, 8'h09, 8'h09},
		'{32'h1D0, 8'h0F, 8'h0F}, '{32'h1D4, 8'hA5, 8'hA5}, '{32'h3FC, 8'hFF, 8'h00}};
	logic [15:0] errRows [6] = '{16'h0001, 16'h0002, 16'h1008, 16'h0804, 16'h0802, 16'h1801};

	t1_tx_maintenance_prbs DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .txBitStrobe(txBitStrobe),
		.txDataIn(txDataIn), .txDataOut(txDataOut), .txDataValid(txDataValid),
		.rxBitStrobe(rxBitStrobe), .rxDataIn(rxDataIn), .txClockSource(txClockSource),
		.txBufferBypass(txBufferBypass), .irq(irq));
	t1_line_model line (.clk(clk), .rst_n(rst_n), .run(run), .txDataOut(txDataOut),
		.txDataValid(txDataValid), .txBitStrobe(txBitStrobe), .txDataIn(txDataIn),
		.rxBitStrobe(rxBitStrobe), .rxDataIn(rxDataIn), .sentBit(sentBit));

	task automatic results;
		if (n_errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic waitReady;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (n >= 20) n_errors++;
	endtask
	task automatic busWrite(input logic [31:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= 1'b1;
		waitReady();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		waitReady();
	endtask
	task automatic busRead(input logic [31:0] a, output logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= 1'b0;
		waitReady();
		hsel <= 1'b0;
		htrans <= 2'h0;
		waitReady();
		d = hrdata;
	endtask
	task automatic expectReg(input logic [31:0] a, input logic [7:0] e);
		logic [31:0] d;
		busRead(a, d);
		check($sformatf("register %0h", a), d, {24'h000000, e});
	endtask
	// Kind 0 expects the sent bit, 1 zeros, 2 ones, 3 only counts ones.
	// Kinds 4 and 5 expect the bit after the F-bit to copy it, with the frame 0 or 1 bit late.
	task automatic watch(input int n, input int k, output int c);
		int j;
		int w;
		logic f;
		bit got;
		c = 0;
		f = 1'b0;
		got = 1'b0;
		repeat (3) @(posedge clk);
		for (j = 0; j < n; j++) begin
			w = 0;
			do begin
				@(posedge clk);
				w++;
			end while (txDataValid !== 1'b1 && w < 20);
			if (w >= 20) n_errors++;
			if (k < 3) check("txDataOut", txDataOut, k == 0 ? sentBit : k == 2);
			if (k > 3 && got && line.sentPos == 8'(k - 3)) check("mimic bit", txDataOut, f);
			if (k > 3 && line.sentPos == 8'(k - 4)) begin
				f = txDataOut;
				got = 1'b1;
			end
			if (txDataOut === 1'b1) c++;
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#9000000;
		n_errors++;
		results();
	end
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h00000000;
		run = 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (i = 0; i < 8; i++) begin
			expectReg(rows[i].addr, 8'h00);
			busWrite(rows[i].addr, rows[i].wdata);
			expectReg(rows[i].addr, rows[i].rdata);
			busWrite(rows[i].addr, 8'h00);
		end
		for (m = 0; m < 4; m++) begin
			for (s = 0; s < 2; s++) begin
				busWrite(32'h188, {1'b0, m[1:0], 5'h01});
				busWrite(32'h1C0, {7'h00, s[0]});
				repeat (2) @(posedge clk);
				es = (m == 0) ? s : (m[0] && s == 1) ? 0 : 2;
				check("txClockSource", txClockSource, es[1:0]);
				check("txBufferBypass", txBufferBypass, !(m[0] && s == 1));
			end
		end
		busWrite(32'h188, 8'h01);
		run <= 1'b1;
		watch(20, 0, ones);
		busWrite(32'h1B0, 8'h02);
		watch(20, 1, ones);
		busWrite(32'h1B0, 8'h01);
		watch(20, 2, ones);
		busWrite(32'h1B0, 8'h03);
		watch(20, 1, ones);
		busWrite(32'h1B0, 8'h00);
		busWrite(32'h1D4, 8'h80);
		for (i = 0; i < 4; i++) begin
			busWrite(32'h1D0, 8'h0C | i[7:0]);
			watch((5 + i) * 12, 3, ones);
			check("code ones", ones, 12);
		end
		busWrite(32'h1D0, 8'h00);
		watch(20, 0, ones);
		for (i = 0; i < 6; i++) begin
			busWrite(32'h188, errRows[i][15:8]);
			busWrite(32'h1BC, errRows[i][7:0]);
			v = 32'h000000FF;
			for (t = 0; t < 60 && v[3:0] !== 4'h0; t++) begin
				repeat (386) @(posedge clk);
				busRead(32'h1BC, v);
			end
			check("error request", v, 0);
		end
		busWrite(32'h188, 8'h01);
		busWrite(32'h1BC, 8'h01);
		repeat (3 * 386) @(posedge clk);
		expectReg(32'h1BC, 8'h01);
		busWrite(32'h1BC, 8'h00);
		busWrite(32'h1B8, 8'h03);
		repeat (13 * 386) @(posedge clk);
		expectReg(32'h1B8, 8'h03);
		check("irq", irq, 0);
		busWrite(32'h1B4, 8'h20);
		repeat (2) @(posedge clk);
		check("irq", irq, 1);
		busWrite(32'h1B8, 8'h02);
		repeat (2) @(posedge clk);
		check("irq", irq, 0);
		busWrite(32'h1B4, 8'h00);
		busWrite(32'h188, 8'h81);
		for (i = 0; i < 3; i++) begin
			busWrite(32'h1C4, i[7:0]);
			repeat (800) @(posedge clk);
			expectReg(32'h1C8, 8'h02);
		end
		busWrite(32'h1CC, 8'h09);
		busWrite(32'h1C8, 8'h09);
		busWrite(32'h1C4, 8'h06);
		repeat (400) @(posedge clk);
		expectReg(32'h1C8, 8'h09);
		expectReg(32'h1CC, 8'h09);
		check("irq", irq, 1);
		busWrite(32'h1C4, 8'h0E);
		repeat (800) @(posedge clk);
		expectReg(32'h1C8, 8'h0B);
		busWrite(32'h1CC, 8'h09);
		expectReg(32'h1CC, 8'h00);
		check("irq", irq, 0);
		busWrite(32'h1C8, 8'h0D);
		repeat (100) @(posedge clk);
		expectReg(32'h1C8, 8'h0B);
		expectReg(32'h1CC, 8'h08);
		check("irq", irq, 1);
		// The slip moves the frame against the line model, so it runs last.
		busWrite(32'h188, 8'h00);
		busWrite(32'h1B0, 8'h08);
		watch(400, 4, ones);
		busWrite(32'h1B0, 8'h0C);
		repeat (10) @(posedge clk);
		watch(400, 5, ones);
		busWrite(32'h1B0, 8'h00);
		results();
	end
endmodule // t1_tx_maintenance_prbs_tb
